// >>> dv/dbp_bank_sva.sv
// Port-level checks for the drive basic parameter bank
`timescale 1ns/10ps
module dbp_bank_sva #(
  parameter logic [15:0] SERIES_CODE = 16'h005A // Arbitrary neutral value
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic motor_type_i,
  input wire logic fifth_digital_input_i,
  input wire logic hand_sel_term_i,
  input wire logic hand_term_en_i,
  input wire logic hand_off_auto_policy_i,
  input wire logic term41_i,
  input wire logic term42_i,
  input wire logic at_min_freq_i,
  input wire logic [1:0] ctl_mode_o,
  input wire logic pulse_ref_o,
  input wire logic remote_mode_o,
  input wire logic run_en_o,
  input wire logic jog_en_o,
  input wire logic decel_o,
  input wire logic [7:0] route_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Register port and control mode
  a_series_read: assert property (rd_i && addr_i == 8'h12 |=> rdata_o == SERIES_CODE)
    else $error("bad series code");
  a_induction_svc: assert property (ctl_mode_o == 2'd1 |-> !$past(motor_type_i))
    else $error("induction vector with magnet motor");
  a_magnet_svc: assert property (ctl_mode_o == 2'd2 |-> $past(motor_type_i))
    else $error("magnet vector with induction motor");
  // Async pins reach registered outputs three cycles late
  a_pulse_route: assert property (
    route_o[2] && $past(route_o[2]) |-> pulse_ref_o == $past(fifth_digital_input_i, 3))
    else $error("pulse reference not from fifth input");
  a_term_hand: assert property ((hand_term_en_i && hand_sel_term_i)[*4] |-> !remote_mode_o)
    else $error("terminal hand request lost");
  a_hoa_block: assert property (
    (hand_off_auto_policy_i && !term41_i && !term42_i)[*4] |-> !run_en_o && !jog_en_o)
    else $error("run or jog passed while blocked");
  a_dir_one_open: assert property ($past(rst_n_i) |-> route_o[1:0] != 2'b00)
    else $error("both directions inhibited");
  a_ramp_end: assert property (at_min_freq_i[*5] |-> !decel_o)
    else $error("ramp kept past minimum frequency");
endmodule : dbp_bank_sva

// >>> dv/dbp_host_model.sv
// Host that reaches the bank over its parameter port
`timescale 1ns/10ps
module dbp_host_model (
  input wire logic core_clk_i,
  input wire logic [15:0] rdata_i,
  output dbp_pkg::dbp_bus_t bus_o
);
  initial bus_o = '0;
  // Strobe stays up until the caller idles, so writes may follow back to back
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0}; // Values go out in binary
    @(posedge core_clk_i);
  endtask : wr
  // Read data stand only in the next cycle; taken at the edge that closes it
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    bus_o <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    bus_o <= '{addr: ~a, wdata: 16'hFFFF, wr: 1'b0, rd: 1'b0};
    @(posedge core_clk_i);
    d = rdata_i;
  endtask : rd
endmodule : dbp_host_model

// >>> dv/test_dbp_bank.sv
// Self-checking bench for the drive basic parameter bank
`timescale 1ns/10ps
module test_dbp_bank;
  logic core_clk, rst_n, mt, di5, hsel, hen, hkey, hand_off_auto_policy, t41, t42, run, jog, stp, uv, flt, amin;
  logic pref, rem, ren, jen, oen, dec;
  logic [15:0] kf, rdata, got;
  logic [1:0] ctl;
  logic [7:0] route;
  dbp_pkg::dbp_bus_t bus;
  int error_cnt = 0;
  int compares = 0;
  // Rows: offset, value written, value read back
  logic [39:0] rows [24] = '{40'h10_0000_0000, 40'h41_FFFF_7878, 40'h42_0000_7896, 40'h41_9696_9696,
    40'h10_0002_0000, 40'h10_0001_0001, 40'h41_FFFF_B4B4, 40'h41_C8C8_C8C8,
    40'h42_0000_96C8, 40'h11_000F_000F, 40'h11_0010_000F, 40'h12_0000_005A,
    40'h14_0007_0007, 40'h14_0005_0007, 40'h15_0002_0002, 40'h15_0003_0002,
    40'h16_0001_0001, 40'h16_0003_0001, 40'h17_0002_0002, 40'h17_0003_0002,
    40'h19_01A3_01A3, 40'h19_0250_01A3, 40'h19_0004_01A3, 40'h13_1234_0000};
  logic [23:0] rst_tab [9] = '{24'h10_0001, 24'h11_0004, 24'h14_0000, 24'h15_0000, 24'h16_0000,
    24'h17_0000, 24'h19_0000, 24'h41_B4B4, 24'h42_96C8};
  dbp_host_model i_dbp_host_model (.core_clk_i(core_clk), .rdata_i(rdata), .bus_o(bus));
  dbp_bank i_dbp_bank (.core_clk_i(core_clk), .rst_n_i(rst_n), .addr_i(bus.addr), .wdata_i(bus.wdata),
    .wr_i(bus.wr), .rd_i(bus.rd), .rdata_o(rdata), .motor_type_i(mt), .fifth_digital_input_i(di5),
    .hand_sel_term_i(hsel), .hand_term_en_i(hen), .hand_key_i(hkey), .hand_off_auto_policy_i(hand_off_auto_policy),
    .term41_i(t41), .term42_i(t42), .run_cmd_i(run), .jog_cmd_i(jog), .stop_cmd_i(stp),
    .undervoltage_event_i(uv), .fault_i(flt), .keypad_freq_i(kf), .at_min_freq_i(amin),
    .ctl_mode_o(ctl), .pulse_ref_o(pref), .remote_mode_o(rem), .run_en_o(ren), .jog_en_o(jen),
    .out_en_o(oen), .decel_o(dec), .route_o(route));
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // Write then drop the strobe, so pins may change afterwards
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    i_dbp_host_model.wr(a, d);
    i_dbp_host_model.rd(8'h13, got);
  endtask : put
  task automatic chk_pin(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk_pin
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
    i_dbp_host_model.rd(a, got);
    chk_pin($sformatf("reg %h hi", a), e[15:8], got[15:8]);
    chk_pin($sformatf("reg %h lo", a), e[7:0], got[7:0]);
  endtask : chk_reg
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Watchdog sized well past the expected two hundred or so cycles
  initial begin
    #80000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {mt, di5, hsel, hen, hkey, hand_off_auto_policy, t41, t42, run, jog, stp, uv, flt, amin} = '0;
    kf = 16'h0000;
    rst_n = 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    foreach (rst_tab[i]) chk_reg(rst_tab[i][23:16], rst_tab[i][15:0]);
    foreach (rows[i]) begin
      i_dbp_host_model.wr(rows[i][39:32], rows[i][31:16]);
      chk_reg(rows[i][39:32], rows[i][15:0]);
    end
    // Selecting PID locks the source until the PID field is cleared
    put(8'h14, 16'h0009);
    chk_reg(8'h40, 16'h0100);
    put(8'h14, 16'h0000);
    chk_reg(8'h14, 16'h0009);
    put(8'h40, 16'h0002);
    put(8'h14, 16'h0004);
    chk_pin("pulse_sel", 8'h01, 8'(route[2]));
    repeat (6) begin
      di5 <= ~di5;
      cyc(1);
    end
    mt <= 1'b1;
    cyc(2);
    chk_pin("ctl", 8'h02, 8'(ctl));
    mt <= 1'b0;
    cyc(2);
    chk_pin("ctl", 8'h01, 8'(ctl));
    put(8'h40, 16'h0000);
    chk_pin("ctl", 8'h00, 8'(ctl));
    // Terminal mode switch overrides the keypad request
    {hen, hsel} <= 2'b11;
    cyc(5);
    chk_pin("remote", 8'h00, 8'(rem));
    {hsel, hkey} <= 2'b01;
    cyc(5);
    chk_pin("remote", 8'h01, 8'(rem));
    {hen, hkey, hand_off_auto_policy, run, jog} <= 5'b00111;
    cyc(5);
    chk_pin("run_jog", 8'h00, {6'h00, ren, jen});
    {hand_off_auto_policy, jog} <= 2'b00;
    cyc(5);
    chk_pin("out_coast", 8'h01, 8'(oen));
    {run, stp} <= 2'b01;
    cyc(5);
    chk_pin("out_coast", 8'h00, {6'h00, oen, dec});
    put(8'h16, 16'h0000);
    {run, stp} <= 2'b10;
    cyc(5);
    {run, stp} <= 2'b01;
    cyc(5);
    chk_pin("ramp", 8'h03, {6'h00, oen, dec});
    {stp, amin} <= 2'b01;
    cyc(6);
    chk_pin("ramp", 8'h00, {6'h00, oen, dec});
    // Keypad command captured on undervoltage, then on fault
    put(8'h14, 16'h0000);
    {amin, uv} <= 2'b01;
    kf <= 16'h1770;
    cyc(5);
    uv <= 1'b0;
    cyc(5);
    chk_reg(8'h18, 16'h1770);
    kf <= 16'h0BB8;
    flt <= 1'b1;
    cyc(5);
    flt <= 1'b0;
    cyc(5);
    chk_reg(8'h18, 16'h0BB8);
    // Second reset while in hand mode
    hkey <= 1'b1;
    cyc(5);
    rst_n <= 1'b0;
    cyc(2);
    chk_pin("remote", 8'h01, 8'(rem));
    {hkey, rst_n} <= 2'b01;
    cyc(2);
    chk_pin("remote", 8'h01, 8'(rem));
    chk_reg(8'h11, 16'h0004);
    wrap_up();
  end
endmodule : test_dbp_bank
bind dbp_bank dbp_bank_sva #(.SERIES_CODE(SERIES_CODE)) i_dbp_bank_sva (.core_clk_i, .rst_n_i, .addr_i,
  .rd_i, .rdata_o, .motor_type_i, .fifth_digital_input_i, .hand_sel_term_i, .hand_term_en_i,
  .hand_off_auto_policy_i, .term41_i, .term42_i, .at_min_freq_i, .ctl_mode_o, .pulse_ref_o,
  .remote_mode_o, .run_en_o, .jog_en_o, .decel_o, .route_o);

// >>> logic/dbp_bank.sv
// Drive basic parameter bank with register port and run/stop sequencing
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`include "dbp_params.svh"
module dbp_bank #(
  parameter logic [15:0] SERIES_CODE = 16'h005A, // Arbitrary neutral identifier
  parameter bit LARGE_RATING = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic motor_type_i,
  input wire logic fifth_digital_input_i,
  input wire logic hand_sel_term_i,
  input wire logic hand_term_en_i,
  input wire logic hand_key_i,
  input wire logic hand_off_auto_policy_i,
  input wire logic term41_i,
  input wire logic term42_i,
  input wire logic run_cmd_i,
  input wire logic jog_cmd_i,
  input wire logic stop_cmd_i,
  input wire logic undervoltage_event_i,
  input wire logic fault_i,
  input wire logic [15:0] keypad_freq_i,
  input wire logic at_min_freq_i,
  output logic [1:0] ctl_mode_o,
  output logic pulse_ref_o,
  output logic remote_mode_o,
  output logic run_en_o,
  output logic jog_en_o,
  output logic out_en_o,
  output logic decel_o,
  output logic [7:0] route_o
);
  dbp_pkg::dbp_bus_t bus;
  logic [15:0] load_q, load_d, car_q, car_d, fsrc_q, fsrc_d, rsrc_q, rsrc_d;
  logic [15:0] stop_q, stop_d, dir_q, dir_d, kmem_q, kmem_d, disp_q, disp_d;
  logic [15:0] spd_q, spd_d, pid_q, pid_d, acc_stall_q, acc_stall_d, run_stall_q, run_stall_d;
  logic [15:0] rdata_q, rdata_d, stall_max, stall_def, car_max;
  logic [1:0] mode_q, mode_d, sync_a_q, sync_b_q;
  logic [5:0] meta_q, sync_q;
  logic remote_q, remote_d, run_q, run_d, jog_q, jog_d, pulse_q, pulse_d;
  logic out_q, out_d, dec_q, dec_d, load_chg;
  dbp_pkg::dbp_out_state_t st_q, st_d;
  dbp_pkg::dbp_route_t route_q, route_d;
  logic [15:0] ovl_peak, ovl_min;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Two-stage synchronisers for terminal, stop and status pins; run, jog, hand key, hand enable and policy inputs are not synchronised
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
      sync_a_q <= 2'h0;
      sync_b_q <= 2'h0;
    end else begin
      meta_q <= {fifth_digital_input_i, hand_sel_term_i, term41_i, term42_i, undervoltage_event_i, fault_i};
      sync_q <= meta_q;
      sync_a_q <= {stop_cmd_i, at_min_freq_i};
      sync_b_q <= sync_a_q;
    end
  end

  // Duty-dependent limits and ratings; the carrier limit follows LARGE_RATING
  always_comb begin
    stall_max = load_q[0] ? `DBP_CT_STALL_MAX : `DBP_VT_STALL_MAX;
    stall_def = wdata_i[0] ? `DBP_CT_STALL_DEF : `DBP_VT_STALL_DEF;
    ovl_peak = load_q[0] ? `DBP_CT_OVL_PEAK : `DBP_VT_OVL_PEAK;
    ovl_min = load_q[0] ? `DBP_CT_OVL_MIN : `DBP_VT_OVL_MIN;
    car_max = LARGE_RATING ? `DBP_CAR_MAX_LARGE : `DBP_CAR_MAX_SMALL;
  end

  // Register writes: illegal values are dropped so the old setting stays live
  always_comb begin
    load_d = load_q;
    car_d = car_q;
    fsrc_d = fsrc_q;
    rsrc_d = rsrc_q;
    stop_d = stop_q;
    dir_d = dir_q;
    disp_d = disp_q;
    spd_d = spd_q;
    pid_d = pid_q;
    acc_stall_d = acc_stall_q;
    run_stall_d = run_stall_q;
    load_chg = 1'b0;
    if (bus.wr) begin
      unique case (bus.addr)
        `DBP_OFS_LOAD_DUTY: if (bus.wdata <= 16'h0001) begin
          load_d = bus.wdata;
          load_chg = 1'b1;
        end
        `DBP_OFS_CARRIER: if (bus.wdata >= `DBP_CAR_MIN && bus.wdata <= car_max) car_d = bus.wdata;
        `DBP_OFS_FREQ_SRC: begin
          // PID lock: leaving 9 needs the PID field moved off 1 first
          if ((bus.wdata <= 16'h0004 || bus.wdata == 16'h0007 || bus.wdata == 16'h0009) &&
              !(fsrc_q == 16'h0009 && pid_q == `DBP_PID_ON && bus.wdata != 16'h0009)) begin
            fsrc_d = bus.wdata;
            if (bus.wdata == 16'h0009) pid_d = `DBP_PID_ON;
          end
        end
        `DBP_OFS_RUN_SRC: if (bus.wdata <= 16'h0002) rsrc_d = bus.wdata;
        `DBP_OFS_STOP: if (bus.wdata <= 16'h0002) stop_d = bus.wdata;
        `DBP_OFS_DIR: if (bus.wdata <= 16'h0002) dir_d = bus.wdata;
        `DBP_OFS_DISPLAY: if (bus.wdata[3:0] <= `DBP_DEC_MAX && bus.wdata[15:4] <= `DBP_UNIT_MAX) begin
          disp_d = bus.wdata;
        end
        `DBP_OFS_CTRL: if (bus.wdata[7:0] == 8'h00 || bus.wdata[7:0] == 8'h02) begin
          spd_d = {8'h00, bus.wdata[7:0]};
          pid_d = {15'h0000, bus.wdata[8]};
        end
        `DBP_OFS_STALL: if (bus.wdata[7:0] <= stall_max[7:0] && bus.wdata[15:8] <= stall_max[7:0]) begin
          acc_stall_d = {8'h00, bus.wdata[7:0]};
          run_stall_d = {8'h00, bus.wdata[15:8]};
        end
        default: ;
      endcase
    end
    // A duty change reloads both stall levels with that duty's default
    if (load_chg) begin
      acc_stall_d = stall_def;
      run_stall_d = stall_def;
    end
  end

  // Control mode, routing and hand/auto selection
  always_comb begin
    mode_d = dbp_pkg::DBP_CTL_VF;
    if (spd_q == 16'h0002) mode_d = motor_type_i ? dbp_pkg::DBP_CTL_PM_SVC : dbp_pkg::DBP_CTL_IM_SVC;
    pulse_d = (fsrc_q == 16'h0004) && sync_q[5];
    // Terminal select outranks the keypad key when enabled
    remote_d = hand_term_en_i ? !sync_q[4] : !hand_key_i;
    route_d = '{freq_src: fsrc_q[2:0], run_src: rsrc_q[1:0], pulse_sel: fsrc_q == 16'h0004,
                rev_ok: dir_q != 16'h0001, fwd_ok: dir_q != 16'h0002};
    // HAND_OFF_AUTO_POLICY with both hand/auto terminals low blocks run and jog
    run_d = run_cmd_i && !(hand_off_auto_policy_i && !sync_q[3] && !sync_q[2]);
    jog_d = jog_cmd_i && !(hand_off_auto_policy_i && !sync_q[3] && !sync_q[2]);
  end

  // Output sequencing on stop
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      dbp_pkg::DBP_OUT_OFF: if (run_q && !sync_b_q[1]) st_d = dbp_pkg::DBP_OUT_RUN;
      dbp_pkg::DBP_OUT_RUN: if (sync_b_q[1]) begin
        st_d = (stop_q == 16'h0001) ? dbp_pkg::DBP_OUT_OFF : dbp_pkg::DBP_OUT_RAMP;
      end
      dbp_pkg::DBP_OUT_RAMP: if (sync_b_q[0]) st_d = dbp_pkg::DBP_OUT_OFF;
    endcase
    out_d = st_d != dbp_pkg::DBP_OUT_OFF;
    dec_d = st_d == dbp_pkg::DBP_OUT_RAMP;
  end

  // Keypad frequency memory and read mux
  always_comb begin
    kmem_d = kmem_q;
    if (fsrc_q == 16'h0000 && (sync_q[1] || sync_q[0])) kmem_d = keypad_freq_i;
    rdata_d = 16'h0000;
    if (bus.rd) begin
      unique case (bus.addr)
        `DBP_OFS_LOAD_DUTY: rdata_d = load_q;
        `DBP_OFS_CARRIER: rdata_d = car_q;
        `DBP_OFS_SERIES: rdata_d = SERIES_CODE;
        `DBP_OFS_FREQ_SRC: rdata_d = fsrc_q;
        `DBP_OFS_RUN_SRC: rdata_d = rsrc_q;
        `DBP_OFS_STOP: rdata_d = stop_q;
        `DBP_OFS_DIR: rdata_d = dir_q;
        `DBP_OFS_KEY_MEM: rdata_d = kmem_q;
        `DBP_OFS_DISPLAY: rdata_d = disp_q;
        `DBP_OFS_CTRL: rdata_d = {7'h00, pid_q[0], spd_q[7:0]};
        `DBP_OFS_STALL: rdata_d = {run_stall_q[7:0], acc_stall_q[7:0]};
        `DBP_OFS_STATUS: rdata_d = {ovl_min[7:0], ovl_peak[7:0]} ^ 16'h0000;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // State registers; remote mode is forced at every power-up
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_q <= `DBP_RST_LOAD_DUTY;
      car_q <= `DBP_RST_CARRIER;
      fsrc_q <= `DBP_RST_ZERO;
      rsrc_q <= `DBP_RST_ZERO;
      stop_q <= `DBP_RST_ZERO;
      dir_q <= `DBP_RST_ZERO;
      kmem_q <= `DBP_RST_ZERO;
      disp_q <= `DBP_RST_ZERO;
      spd_q <= `DBP_RST_ZERO;
      pid_q <= `DBP_RST_ZERO;
      acc_stall_q <= `DBP_CT_STALL_DEF;
      run_stall_q <= `DBP_CT_STALL_DEF;
      rdata_q <= `DBP_RST_ZERO;
      mode_q <= dbp_pkg::DBP_CTL_VF;
      remote_q <= 1'b1;
      run_q <= 1'b0;
      jog_q <= 1'b0;
      pulse_q <= 1'b0;
      out_q <= 1'b0;
      dec_q <= 1'b0;
      st_q <= dbp_pkg::DBP_OUT_OFF;
      // Matches the reset direction setting: both directions open
      route_q <= '{freq_src: 3'h0, run_src: 2'h0, pulse_sel: 1'b0, rev_ok: 1'b1, fwd_ok: 1'b1};
    end else begin
      load_q <= load_d;
      car_q <= car_d;
      fsrc_q <= fsrc_d;
      rsrc_q <= rsrc_d;
      stop_q <= stop_d;
      dir_q <= dir_d;
      kmem_q <= kmem_d;
      disp_q <= disp_d;
      spd_q <= spd_d;
      pid_q <= pid_d;
      acc_stall_q <= acc_stall_d;
      run_stall_q <= run_stall_d;
      rdata_q <= rdata_d;
      mode_q <= mode_d;
      remote_q <= remote_d;
      run_q <= run_d;
      jog_q <= jog_d;
      pulse_q <= pulse_d;
      out_q <= out_d;
      dec_q <= dec_d;
      st_q <= st_d;
      route_q <= route_d;
    end
  end

  assign rdata_o = rdata_q;
  assign ctl_mode_o = mode_q;
  assign pulse_ref_o = pulse_q;
  assign remote_mode_o = remote_q;
  assign run_en_o = run_q;
  assign jog_en_o = jog_q;
  assign out_en_o = out_q;
  assign decel_o = dec_q;
  assign route_o = route_q;
endmodule : dbp_bank

// >>> logic/dbp_params.svh
// Offsets, field positions, reset values and limits of the drive basic parameter bank
`ifndef DBP_PARAMS_SVH
`define DBP_PARAMS_SVH
`define DBP_OFS_LOAD_DUTY 8'h10
`define DBP_OFS_CARRIER 8'h11
`define DBP_OFS_SERIES 8'h12
`define DBP_OFS_FREQ_SRC 8'h14
`define DBP_OFS_RUN_SRC 8'h15
`define DBP_OFS_STOP 8'h16
`define DBP_OFS_DIR 8'h17
`define DBP_OFS_KEY_MEM 8'h18
`define DBP_OFS_DISPLAY 8'h19
`define DBP_OFS_CTRL 8'h40
`define DBP_OFS_STALL 8'h41
`define DBP_OFS_STATUS 8'h42
`define DBP_RST_LOAD_DUTY 16'h0001
`define DBP_RST_CARRIER 16'h0004
`define DBP_RST_ZERO 16'h0000
`define DBP_CAR_MIN 16'h0002
`define DBP_CAR_MAX_SMALL 16'h000F
`define DBP_CAR_MAX_LARGE 16'h000A
`define DBP_VT_STALL_DEF 16'h0078
`define DBP_VT_STALL_MAX 16'h0096
`define DBP_CT_STALL_DEF 16'h00B4
`define DBP_CT_STALL_MAX 16'h00C8
`define DBP_VT_OVL_PEAK 16'h0096
`define DBP_VT_OVL_MIN 16'h0078
`define DBP_CT_OVL_PEAK 16'h00C8
`define DBP_CT_OVL_MIN 16'h0096
`define DBP_OVL_PEAK_S 16'h0003
`define DBP_OVL_MIN_S 16'h003C
`define DBP_UNIT_MAX 12'h024
`define DBP_DEC_MAX 4'h3
`define DBP_DEC_LSB 0
`define DBP_UNIT_LSB 4
`define DBP_PID_ON 16'h0001
`endif

// >>> logic/dbp_pkg.sv
// Types shared by the drive basic parameter bank
package dbp_pkg;
  typedef enum logic [1:0] {DBP_CTL_VF, DBP_CTL_IM_SVC, DBP_CTL_PM_SVC} dbp_ctl_t;
  typedef enum logic [1:0] {DBP_OUT_OFF, DBP_OUT_RUN, DBP_OUT_RAMP} dbp_out_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dbp_bus_t;
  typedef struct packed {
    logic [2:0] freq_src;
    logic [1:0] run_src;
    logic pulse_sel;
    logic rev_ok;
    logic fwd_ok;
  } dbp_route_t;
endpackage : dbp_pkg
